// *** rtl/ers_sequencer.sv ***
// Exposure and readout sequencer of an electron-multiplying CCD camera.
// Assumes configuration held steady by a command decoder, trigger, link clock and
// over-temperature arriving as raw pins, and sensor samples on clk_i.

`timescale 1ns/1ns

module ers_sequencer #(
  parameter int COLS      = ers_pkg::SENSOR_COLS,
  parameter int ROWS      = ers_pkg::SENSOR_ROWS,
  parameter int CLEAR_LEN = ers_pkg::CLEAR_CYC
) (
  input  wire logic                         clk_i,
  input  wire logic                         rst_n_i,
  input  wire ers_pkg::ers_cfg_s            cfg_i,
  input  wire logic                         trig_i,
  input  wire logic                         link_clk_i,
  input  wire logic                         over_temp_i,
  input  wire logic [ers_pkg::PIX_W-1:0]    sensor_pix_i,
  output ers_pkg::ers_pix_s                 pix_o,
  output logic                              frame_valid_o,
  output logic                              line_valid_o,
  output logic                              standby_o,
  output logic                              fast_clear_o,
  output logic                              integrate_o,
  output logic                              beep_o
);

  // ==========================================================================
  // State
  ers_pkg::ers_state_s s_r;
  ers_pkg::ers_state_s s_nxt;

  logic                             trg_act_now;
  logic                             trg_rise;
  logic                             lk_edge;
  logic                             exp_done;
  logic [ers_pkg::SHIFT_W-1:0]      shift;
  logic [ers_pkg::COL_W-1:0]        cols_last;
  logic [ers_pkg::ROW_W-1:0]        rows_last;

  // ==========================================================================
  // Binning factor to shift
  function automatic logic [ers_pkg::SHIFT_W-1:0] bin_shift(
    input logic [ers_pkg::BIN_W-1:0] f
  );
    logic [ers_pkg::SHIFT_W-1:0] r;
    r = 3'h0;
    unique case (f)
      5'h02: r = 3'h1;
      5'h04: r = 3'h2;
      5'h08: r = 3'h3;
      5'h10: r = 3'h4;
      default: r = 3'h0;
    endcase
    return r;
  endfunction

  // ==========================================================================
  // Frame geometry from scan mode
  always_comb begin
    shift     = 3'h0;
    cols_last = ers_pkg::COL_W'(COLS - 1);
    rows_last = ers_pkg::ROW_W'(ROWS - 1);
    unique case (cfg_i.scan)
      ers_pkg::ERS_SCAN_BINNED: begin
        shift     = bin_shift(cfg_i.binning_factor_command);
        cols_last = ers_pkg::COL_W'((COLS >> shift) - 1);
        rows_last = ers_pkg::ROW_W'((ROWS >> shift) - 1);
      end
      ers_pkg::ERS_SCAN_SUBARRAY: begin
        if (cfg_i.sub_rows != '0) begin
          rows_last = cfg_i.sub_rows - 11'h001;
        end else begin
          rows_last = 11'h000;
        end
      end
      default: begin
        shift = 3'h0;
      end
    endcase
  end

  // ==========================================================================
  // Pin conditioning and edge finding
  always_comb begin
    trg_act_now = cfg_i.trig_pos ? s_r.trg_lvl : ~s_r.trg_lvl;
    // Standby gate hides the false edge of a low-active pin after reset
    trg_rise    = trg_act_now & ~s_r.trg_act & s_r.standby;
    lk_edge     = (s_r.lk_sync[1] == s_r.lk_sync[2]) & s_r.lk_sync[2] & ~s_r.lk_lvl;
    exp_done    = s_r.tick & ((s_r.exp_cnt + 24'h000001) >= cfg_i.exp_us);
  end

  // ==========================================================================
  // Next state
  always_comb begin
    s_nxt = s_r;

    s_nxt.trg_sync = {s_r.trg_sync[1:0], trig_i};
    if (s_r.trg_sync[1] == s_r.trg_sync[2]) begin
      s_nxt.trg_lvl = s_r.trg_sync[2];
    end
    s_nxt.trg_act = trg_act_now;

    s_nxt.lk_sync = {s_r.lk_sync[1:0], link_clk_i};
    if (s_r.lk_sync[1] == s_r.lk_sync[2]) begin
      s_nxt.lk_lvl = s_r.lk_sync[2];
    end

    s_nxt.ot_sync = {s_r.ot_sync[1:0], over_temp_i};
    if (s_r.ot_sync[1] == s_r.ot_sync[2]) begin
      s_nxt.ot_lvl = s_r.ot_sync[2];
    end

    // Microsecond tick
    s_nxt.tick = 1'b0;
    if (s_r.tick_cnt == ers_pkg::TICK_W'(ers_pkg::TICK_CYC - 1)) begin
      s_nxt.tick_cnt = '0;
      s_nxt.tick     = 1'b1;
    end else begin
      s_nxt.tick_cnt = s_r.tick_cnt + 7'h01;
    end

    // Alarm tone
    if (!s_r.ot_lvl) begin
      s_nxt.beep_cnt = '0;
      s_nxt.beep     = 1'b0;
    end else if (s_r.tick) begin
      if (s_r.beep_cnt == ers_pkg::BEEP_W'(ers_pkg::BEEP_HALF_US - 1)) begin
        s_nxt.beep_cnt = '0;
        s_nxt.beep     = ~s_r.beep;
      end else begin
        s_nxt.beep_cnt = s_r.beep_cnt + 8'h01;
      end
    end

    // Sequencer
    s_nxt.pix.valid = 1'b0;
    s_nxt.pix.sof   = 1'b0;
    s_nxt.pix.eol   = 1'b0;
    unique case (s_r.st)
      ers_pkg::ERS_IDLE: begin
        if (!cfg_i.ext_mode) begin
          s_nxt.st      = ers_pkg::ERS_EXPOSE;
          s_nxt.exp_cnt = '0;
        end else if (trg_rise) begin
          s_nxt.st      = ers_pkg::ERS_CLEAR;
          s_nxt.clr_cnt = '0;
        end
      end
      ers_pkg::ERS_CLEAR: begin
        if (s_r.clr_cnt == ers_pkg::COL_W'(CLEAR_LEN - 1)) begin
          s_nxt.st      = ers_pkg::ERS_EXPOSE;
          s_nxt.exp_cnt = '0;
        end else begin
          s_nxt.clr_cnt = s_r.clr_cnt + 11'h001;
        end
      end
      ers_pkg::ERS_EXPOSE: begin
        if (cfg_i.ext_mode && cfg_i.level_mode) begin
          if (!trg_act_now) begin
            s_nxt.st = ers_pkg::ERS_READ;
          end
        end else if (exp_done) begin
          s_nxt.st = ers_pkg::ERS_READ;
        end else if (s_r.tick) begin
          s_nxt.exp_cnt = s_r.exp_cnt + 24'h000001;
        end
        if (s_nxt.st == ers_pkg::ERS_READ) begin
          s_nxt.col      = '0;
          s_nxt.row      = '0;
          s_nxt.first    = 1'b1;
          s_nxt.col_last = cols_last;
          s_nxt.row_last = rows_last;
        end
      end
      ers_pkg::ERS_READ: begin
        if (lk_edge) begin
          s_nxt.pix.valid = 1'b1;
          s_nxt.pix.sof   = s_r.first;
          s_nxt.pix.data  = sensor_pix_i;
          s_nxt.first     = 1'b0;
          if (s_r.col == s_r.col_last) begin
            s_nxt.pix.eol = 1'b1;
            s_nxt.col     = '0;
            if (s_r.row == s_r.row_last) begin
              if (cfg_i.ext_mode) begin
                s_nxt.st = ers_pkg::ERS_IDLE;
              end else begin
                s_nxt.st      = ers_pkg::ERS_EXPOSE;
                s_nxt.exp_cnt = '0;
              end
            end else begin
              s_nxt.row = s_r.row + 11'h001;
            end
          end else begin
            s_nxt.col = s_r.col + 11'h001;
          end
        end
      end
    endcase

    // Status outputs registered from the next state
    s_nxt.standby     = (s_nxt.st == ers_pkg::ERS_IDLE);
    s_nxt.fast_clear  = (s_nxt.st == ers_pkg::ERS_CLEAR);
    s_nxt.integrate   = (s_nxt.st == ers_pkg::ERS_EXPOSE);
    s_nxt.frame_valid = (s_nxt.st == ers_pkg::ERS_READ);
    s_nxt.line_valid  = (s_nxt.st == ers_pkg::ERS_READ) && !s_nxt.pix.eol;
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================================
  // Outputs
  assign pix_o         = s_r.pix;
  assign frame_valid_o = s_r.frame_valid;
  assign line_valid_o  = s_r.line_valid;
  assign standby_o     = s_r.standby;
  assign fast_clear_o  = s_r.fast_clear;
  assign integrate_o   = s_r.integrate;
  assign beep_o        = s_r.beep;

endmodule

// *** pkg/ers_pkg.sv ***
// Shared types and constants of the exposure and readout sequencer.
// Assumes a single 100 MHz clock domain; the link clock and pins arrive unsynchronised.
package ers_pkg;

  // ==========================================================================
  // Timing
  localparam int CLK_HZ       = 100_000_000;
  localparam int TIME_UNIT_NS = 1000;
  localparam int TICK_CYC     = (TIME_UNIT_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int BEEP_HALF_US = 250;

  // ==========================================================================
  // Geometry and widths
  localparam int SENSOR_COLS = 1000;
  localparam int SENSOR_ROWS = 1000;
  localparam int CLEAR_CYC   = SENSOR_ROWS;
  localparam int PIX_W       = 14;
  localparam int COL_W       = 11;
  localparam int ROW_W       = 11;
  localparam int EXP_W       = 24;
  localparam int TICK_W      = 7;
  localparam int BEEP_W      = 8;
  localparam int BIN_W       = 5;
  localparam int SHIFT_W     = 3;

  // ==========================================================================
  // Reset values of configuration fields
  localparam logic [EXP_W-1:0] EXP_US_RESET = 24'h007d00;
  localparam logic [BIN_W-1:0] BIN_RESET    = 5'h01;

  // ==========================================================================
  // Modes
  typedef enum logic [1:0] {
    ERS_SCAN_NORMAL,
    ERS_SCAN_BINNED,
    ERS_SCAN_SUBARRAY
  } ers_scan_e;

  typedef enum logic [1:0] {
    ERS_IDLE,
    ERS_CLEAR,
    ERS_EXPOSE,
    ERS_READ
  } ers_state_e;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic             ext_mode;
    logic             level_mode;
    logic             trig_pos;
    ers_scan_e        scan;
    logic [BIN_W-1:0] binning_factor_command;
    logic [EXP_W-1:0] exp_us;
    logic [ROW_W-1:0] sub_rows;
  } ers_cfg_s;

  typedef struct packed {
    logic             valid;
    logic             sof;
    logic             eol;
    logic [PIX_W-1:0] data;
  } ers_pix_s;

  typedef struct packed {
    ers_state_e        st;
    logic [2:0]        trg_sync;
    logic              trg_lvl;
    logic              trg_act;
    logic [2:0]        lk_sync;
    logic              lk_lvl;
    logic [2:0]        ot_sync;
    logic              ot_lvl;
    logic [TICK_W-1:0] tick_cnt;
    logic              tick;
    logic [BEEP_W-1:0] beep_cnt;
    logic [EXP_W-1:0]  exp_cnt;
    logic [COL_W-1:0]  clr_cnt;
    logic [COL_W-1:0]  col;
    logic [ROW_W-1:0]  row;
    logic [COL_W-1:0]  col_last;
    logic [ROW_W-1:0]  row_last;
    logic              first;
    ers_pix_s          pix;
    logic              frame_valid;
    logic              line_valid;
    logic              standby;
    logic              fast_clear;
    logic              integrate;
    logic              beep;
  } ers_state_s;

endpackage

// *** testbench/ers_checker_assertions.sv ***
// Port checker of the exposure and readout sequencer.
// Bound to every ers_sequencer instance; sees its ports only.
`timescale 1ns/1ns
module ers_checker #(
  parameter int CLEAR_LEN = 4
) (
  input wire logic              clk_i,
  input wire logic              rst_n_i,
  input wire ers_pkg::ers_cfg_s cfg_i,
  input wire logic              over_temp_i,
  input wire ers_pkg::ers_pix_s pix_o,
  input wire logic              frame_valid_o,
  input wire logic              line_valid_o,
  input wire logic              standby_o,
  input wire logic              fast_clear_o,
  input wire logic              integrate_o,
  input wire logic              beep_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // ====
  // Clear length counter
  int clr_r;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      clr_r <= 0;
    end else begin
      clr_r <= fast_clear_o ? clr_r + 1 : 0;
    end
  end
  // ====
  // Assertions
  a_clear_len: assert property ($fell(fast_clear_o) |-> clr_r == CLEAR_LEN)
    else $error("fast clear length wrong");
  a_clear_from_idle: assert property ($rose(fast_clear_o) |-> $past(standby_o))
    else $error("clear started outside standby");
  a_clear_ext_only: assert property (!cfg_i.ext_mode |-> !fast_clear_o)
    else $error("clear in internal mode");
  a_states_excl: assert property ($onehot0({standby_o, fast_clear_o, integrate_o, frame_valid_o}))
    else $error("state outputs overlap");
  a_read_after_exp: assert property ($rose(frame_valid_o) |-> $past(integrate_o))
    else $error("readout not after exposure");
  a_pix_in_frame: assert property (pix_o.valid |-> $past(frame_valid_o))
    else $error("pixel outside frame");
  a_eol_gap: assert property (pix_o.valid && pix_o.eol |-> !line_valid_o)
    else $error("line valid high on line end");
  a_sof_valid: assert property (pix_o.sof |-> pix_o.valid)
    else $error("frame start without pixel");
  a_beep_quiet: assert property (!over_temp_i [*8] |-> !beep_o)
    else $error("beep without over temperature");
  c_clear: cover property ($fell(fast_clear_o));
  c_line: cover property (pix_o.valid && pix_o.eol);
  c_beep: cover property ($rose(beep_o));
endmodule
bind ers_sequencer ers_checker #(.CLEAR_LEN(CLEAR_LEN)) chk_u (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .cfg_i(cfg_i), .over_temp_i(over_temp_i),
  .pix_o(pix_o), .frame_valid_o(frame_valid_o), .line_valid_o(line_valid_o),
  .standby_o(standby_o), .fast_clear_o(fast_clear_o), .integrate_o(integrate_o), .beep_o(beep_o));

// *** testbench/ers_host_model.sv ***
// Host side model: paces readout and supplies sensor samples.
// Assumes run_i is high only while a frame is read out.
`timescale 1ns/1ns
module ers_host_model (
  input  wire logic                      run_i,
  output logic                           link_clk_o,
  output logic [ers_pkg::PIX_W-1:0]      sensor_pix_o
);
  // ====
  // Link clock, still outside frames
  initial begin
    link_clk_o = 1'b0;
    sensor_pix_o = 14'h0000;
    forever begin
      wait (run_i);
      #65 link_clk_o = 1'b1;
      #60 link_clk_o = 1'b0;
      sensor_pix_o = sensor_pix_o + 14'h0001;
    end
  end
endmodule

// *** testbench/testbench.sv ***
// Self-checking bench of the sequencer with a small sensor.
// Assumes the checker is bound and the host model paces readout.
`timescale 1ns/1ns
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_fail++; $display("BAD %0t mismatch", $time); end end
module testbench;
  logic                         clk, rst_n, trig, ot, lk, fv, lv, sb, fc, ig, bp;
  logic [ers_pkg::PIX_W-1:0]    spix, prv;
  ers_pkg::ers_cfg_s            cfg, c;
  ers_pkg::ers_pix_s            pix;
  int                           n_fail, cmp_count, npix, nsof, neol, nbad, clr_len, int_len, i, k;
  ers_sequencer #(.COLS(16), .ROWS(16), .CLEAR_LEN(4)) dut_u (.clk_i(clk), .rst_n_i(rst_n), .cfg_i(cfg),
    .trig_i(trig), .link_clk_i(lk), .over_temp_i(ot), .sensor_pix_i(spix), .pix_o(pix), .frame_valid_o(fv),
    .line_valid_o(lv), .standby_o(sb), .fast_clear_o(fc), .integrate_o(ig), .beep_o(bp));
  ers_host_model host_u (.run_i(fv), .link_clk_o(lk), .sensor_pix_o(spix));
  always #5 clk = ~clk;
  // ====
  // Frame monitor
  always @(posedge clk) begin
    if (pix.valid === 1'b1) begin
      npix++;
      nsof += pix.sof;
      neol += pix.eol;
      if (!pix.sof && pix.data !== prv + 14'h0001) nbad++;
      prv = pix.data;
    end
    clr_len += fc;
    int_len += ig;
  end
  // ====
  // Tasks
  task automatic end_of_test;
    if (n_fail == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic zero;
    npix = 0; nsof = 0; neol = 0; nbad = 0; clr_len = 0; int_len = 0;
  endtask
  task automatic restart(input ers_pkg::ers_cfg_s x);
    @(negedge clk);
    rst_n = 1'b0;
    cfg = x;
    trig = ~x.trig_pos;
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    repeat (8) @(negedge clk);
  endtask
  task automatic pulse(input int w);
    @(negedge clk);
    trig = cfg.trig_pos;
    repeat (w) @(negedge clk);
    trig = ~cfg.trig_pos;
  endtask
  task automatic frame(input int w, input int n, input bit two);
    int j;
    zero();
    pulse(w);
    if (two) begin
      repeat (60) @(negedge clk);
      pulse(w);
    end
    for (j = 0; j < 20000 && sb !== 1'b1; j++) @(negedge clk);
    // Last pixel shares its edge with standby
    @(negedge clk);
    `CHK(npix, n)
    `CHK(nsof, 1)
    `CHK(nbad, 0)
    `CHK(clr_len, 4)
  endtask
  // ====
  // Tests
  initial begin
    clk = 1'b0; rst_n = 1'b0; trig = 1'b0; ot = 1'b0; cfg = '0;
    n_fail = 0; cmp_count = 0; prv = 14'h0000;
    zero();
    c = '0;
    c.ext_mode = 1'b1;
    c.trig_pos = 1'b1;
    c.scan = ers_pkg::ERS_SCAN_NORMAL;
    c.binning_factor_command = 5'h01;
    c.exp_us = 24'h000003;
    c.sub_rows = 11'h003;
    restart(c);
    zero();
    repeat (300) @(negedge clk);
    `CHK(sb, 1'b1)
    `CHK(clr_len, 0)
    frame(10, 256, 1'b1);
    `CHK(int_len >= 200 && int_len <= 400, 1'b1)
    c.scan = ers_pkg::ERS_SCAN_BINNED;
    for (k = 1; k < 5; k++) begin
      c.binning_factor_command = 5'(1 << k);
      cfg = c;
      frame(10, (16 >> k) * (16 >> k), 1'b0);
    end
    c.scan = ers_pkg::ERS_SCAN_SUBARRAY;
    cfg = c;
    frame(10, 48, 1'b0);
    `CHK(neol, 3)
    c.scan = ers_pkg::ERS_SCAN_NORMAL;
    c.level_mode = 1'b1;
    c.trig_pos = 1'b0;
    restart(c);
    frame(600, 256, 1'b0);
    `CHK(int_len >= 588 && int_len <= 600, 1'b1)
    c.ext_mode = 1'b0;
    restart(c);
    zero();
    for (i = 0; i < 20000 && neol < 32; i++) @(negedge clk);
    `CHK(neol >= 32, 1'b1)
    `CHK(clr_len, 0)
    ot = 1'b1;
    for (i = 0; i < 30000 && bp !== 1'b1; i++) @(negedge clk);
    `CHK(bp, 1'b1)
    for (i = 0; i < 30000 && bp !== 1'b0; i++) @(negedge clk);
    `CHK(i > 24000 && i < 26000, 1'b1)
    ot = 1'b0;
    repeat (10) @(negedge clk);
    end_of_test();
  end
  initial begin
    #950000;
    n_fail++;
    end_of_test();
  end
endmodule
